// ==== logic/threshold_deadtime_pkg.sv ====
// Operation
// - Unimplemented upper bits of both threshold registers ignore writes and read zero.
// - Rising detector threshold is a 5-bit code, 2.8V plus 0.2V per step.
// - Rising detector threshold register resets to 0x03, the 3.4V code.
// - Second over-voltage threshold is a 6-bit code, 0.5V then 1V steps.
// - Second over-voltage threshold register resets to 0x3F, the 55V code.
// - Top two bits of power stage register select sync pin role and edge.
// - Constant dead time bit removes frequency dependence of minimum dead time.
// - Scaling bit enables dead time scaling with frequency around 2 MHz.
// - Two-bit field selects minimum dead time: 10, 20, 40 or 60 ns.
// - Lowest two bits scale minimum on/off time: 0.75x, 1x, 1.25x, 1.5x.
// - Power stage register resets to 0x15.
`default_nettype none
package threshold_deadtime_pkg;
  // ****************************************
  // Register map
  // ****************************************
  localparam logic [7:0] SUPPLY_DETECT_RISE_LEVEL_OFS  = 8'hd4;
  localparam logic [7:0] SECOND_OVERVOLTAGE_LEVEL_OFS  = 8'hd5;
  localparam logic [7:0] POWER_STAGE_TIMING_CONFIG_OFS = 8'hd6;
  localparam logic [7:0] SUPPLY_DETECT_RISE_LEVEL_RST  = 8'h03;
  localparam logic [7:0] SECOND_OVERVOLTAGE_LEVEL_RST  = 8'h3f;
  localparam logic [7:0] POWER_STAGE_TIMING_CONFIG_RST = 8'h15;
  localparam logic [7:0] SUPPLY_DETECT_RISE_LEVEL_MASK = 8'h1f;
  localparam logic [7:0] SECOND_OVERVOLTAGE_LEVEL_MASK = 8'h3f;
  localparam logic [7:0] UNMAPPED_READ_VALUE           = 8'h00;
  // ****************************************
  // Power stage field positions
  // ****************************************
  localparam int SYNC_ROLE_MSB      = 7;
  localparam int SYNC_ROLE_LSB      = 6;
  localparam int CONST_DEAD_BIT     = 5;
  localparam int DT_SCALE_BIT       = 4;
  localparam int MIN_DEAD_MSB       = 3;
  localparam int MIN_DEAD_LSB       = 2;
  localparam int ON_OFF_FACTOR_MSB  = 1;
  localparam int ON_OFF_FACTOR_LSB  = 0;
  // ****************************************
  // Serial link
  // ****************************************
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  typedef enum logic [2:0] {
    LINK_IDLE, LINK_ADDR, LINK_ADDR_ACK, LINK_RX, LINK_RX_ACK, LINK_TX, LINK_HOST_ACK
  } link_state_t;
endpackage : threshold_deadtime_pkg
`default_nettype wire

// ==== logic/reg_access_if.sv ====
`timescale 1ns/1ps
`default_nettype none
interface reg_access_if;
  logic       wrStrobe;
  logic [7:0] wrAddr;
  logic [7:0] wrData;
  logic [7:0] rdAddr;
  logic [7:0] rdData;
  modport link (output wrStrobe, output wrAddr, output wrData, output rdAddr, input rdData);
  modport regs (input wrStrobe, input wrAddr, input wrData, input rdAddr, output rdData);
endinterface : reg_access_if
`default_nettype wire

// ==== logic/threshold_reg_file.sv ====
`timescale 1ns/1ps
`default_nettype none
module threshold_reg_file
  import threshold_deadtime_pkg::*;
(
  input  wire logic   clk_sys,
  input  wire logic   resetn,
  reg_access_if.regs  bus,
  output logic [7:0]  supplyDetectRise,
  output logic [7:0]  secondOvervoltage,
  output logic [7:0]  powerStageTiming
);
  // ****************************************
  // Storage
  // ****************************************
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      supplyDetectRise  <= SUPPLY_DETECT_RISE_LEVEL_RST;
      secondOvervoltage <= SECOND_OVERVOLTAGE_LEVEL_RST;
      powerStageTiming  <= POWER_STAGE_TIMING_CONFIG_RST;
    end else if (bus.wrStrobe) begin
      case (bus.wrAddr)
        SUPPLY_DETECT_RISE_LEVEL_OFS: begin
          supplyDetectRise <= bus.wrData & SUPPLY_DETECT_RISE_LEVEL_MASK;
        end
        SECOND_OVERVOLTAGE_LEVEL_OFS: begin
          secondOvervoltage <= bus.wrData & SECOND_OVERVOLTAGE_LEVEL_MASK;
        end
        POWER_STAGE_TIMING_CONFIG_OFS: begin
          powerStageTiming <= bus.wrData;
        end
        default: begin
        end
      endcase
    end
  end
  // ****************************************
  // Read mux
  // ****************************************
  always_comb begin
    case (bus.rdAddr)
      SUPPLY_DETECT_RISE_LEVEL_OFS:  bus.rdData = supplyDetectRise;
      SECOND_OVERVOLTAGE_LEVEL_OFS:  bus.rdData = secondOvervoltage;
      POWER_STAGE_TIMING_CONFIG_OFS: bus.rdData = powerStageTiming;
      default:                       bus.rdData = UNMAPPED_READ_VALUE;
    endcase
  end
endmodule : threshold_reg_file
`default_nettype wire

// ==== logic/threshold_deadtime_cfg_regs.sv ====
`timescale 1ns/1ps
`default_nettype none
module threshold_deadtime_cfg_regs
  import threshold_deadtime_pkg::*;
#(
  parameter logic [6:0] DEVICE_ADDRESS = 7'h50 // Arbitrary value
)
(
  input  wire logic       clk_sys,
  input  wire logic       resetn,
  input  wire logic       sclIn,
  input  wire logic       sdaIn,
  output logic            sdaOut,
  output logic            sdaOe,
  output logic [4:0]      supplyDetectRiseCode,
  output logic [5:0]      secondOvervoltageCode,
  output logic [1:0]      syncPinRole,
  output logic            constDeadTimeEnable,
  output logic            deadTimeScalingEnable,
  output logic [1:0]      minDeadTimeSelect,
  output logic [1:0]      minOnOffTimeFactor
);
  reg_access_if regBus ();
  logic [7:0]  supplyDetectRise;
  logic [7:0]  secondOvervoltage;
  logic [7:0]  powerStageTiming;
  logic        sclQ;
  logic        sclPrev;
  logic        sdaQ;
  logic        sdaPrev;
  logic        sclRise;
  logic        sclFall;
  logic        startSeen;
  logic        stopSeen;
  link_state_t state;
  logic [3:0]  bitCnt;
  logic [7:0]  shiftReg;
  logic [7:0]  txData;
  logic [7:0]  pointer;
  logic        isRead;
  logic        gotPointer;
  logic        hostNack;
  logic        sdaLow;
  logic        wrStrobe;
  logic [7:0]  wrAddr;
  logic [7:0]  wrData;

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic isLastBit(input logic [3:0] count);
    return count == BITS_PER_BYTE;
  endfunction : isLastBit

  function automatic logic matchesDevice(input logic [7:0] frame);
    return frame[7:1] == DEVICE_ADDRESS;
  endfunction : matchesDevice

  function automatic logic [7:0] nextPointer(input logic [7:0] ptr);
    return ptr + 8'h01;
  endfunction : nextPointer

  function automatic logic txPull(input logic [7:0] data, input logic [3:0] idx);
    return ~data[3'(4'h7 - idx)];
  endfunction : txPull

  // ****************************************
  // Register storage
  // ****************************************
  threshold_reg_file regFile (
    .clk_sys           (clk_sys),
    .resetn            (resetn),
    .bus               (regBus),
    .supplyDetectRise  (supplyDetectRise),
    .secondOvervoltage (secondOvervoltage),
    .powerStageTiming  (powerStageTiming)
  );

  assign regBus.wrStrobe = wrStrobe;
  assign regBus.wrAddr   = wrAddr;
  assign regBus.wrData   = wrData;
  assign regBus.rdAddr   = pointer;

  // ****************************************
  // Field outputs
  // ****************************************
  assign supplyDetectRiseCode  = supplyDetectRise[4:0];
  assign secondOvervoltageCode = secondOvervoltage[5:0];
  assign syncPinRole           = powerStageTiming[SYNC_ROLE_MSB:SYNC_ROLE_LSB];
  assign constDeadTimeEnable   = powerStageTiming[CONST_DEAD_BIT];
  assign deadTimeScalingEnable = powerStageTiming[DT_SCALE_BIT];
  assign minDeadTimeSelect     = powerStageTiming[MIN_DEAD_MSB:MIN_DEAD_LSB];
  assign minOnOffTimeFactor    = powerStageTiming[ON_OFF_FACTOR_MSB:ON_OFF_FACTOR_LSB];

  // ****************************************
  // Line sampling
  // ****************************************
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      sclQ    <= 1'b1;
      sclPrev <= 1'b1;
      sdaQ    <= 1'b1;
      sdaPrev <= 1'b1;
    end else begin
      sclQ    <= sclIn;
      sclPrev <= sclQ;
      sdaQ    <= sdaIn;
      sdaPrev <= sdaQ;
    end
  end

  assign sclRise   = sclQ & ~sclPrev;
  assign sclFall   = ~sclQ & sclPrev;
  assign startSeen = sclQ & sclPrev & sdaPrev & ~sdaQ;
  assign stopSeen  = sclQ & sclPrev & ~sdaPrev & sdaQ;
  assign sdaOut    = 1'b0;
  assign sdaOe     = sdaLow;

  // ****************************************
  // Link state machine
  // ****************************************
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      state      <= LINK_IDLE;
      bitCnt     <= 4'h0;
      shiftReg   <= 8'h00;
      txData     <= 8'h00;
      pointer    <= 8'h00;
      isRead     <= 1'b0;
      gotPointer <= 1'b0;
      hostNack   <= 1'b0;
      sdaLow     <= 1'b0;
      wrStrobe   <= 1'b0;
      wrAddr     <= 8'h00;
      wrData     <= 8'h00;
    end else begin
      wrStrobe <= 1'b0;
      if (startSeen) begin
        state      <= LINK_ADDR;
        bitCnt     <= 4'h0;
        gotPointer <= 1'b0;
        sdaLow     <= 1'b0;
      end else if (stopSeen) begin
        state  <= LINK_IDLE;
        sdaLow <= 1'b0;
      end else if (sclRise) begin
        case (state)
          LINK_ADDR, LINK_RX: begin
            shiftReg <= {shiftReg[6:0], sdaQ};
            bitCnt   <= bitCnt + 4'h1;
          end
          LINK_HOST_ACK: begin
            hostNack <= sdaQ;
          end
          default: begin
          end
        endcase
      end else if (sclFall) begin
        case (state)
          LINK_ADDR: begin
            if (isLastBit(bitCnt)) begin
              if (matchesDevice(shiftReg)) begin
                state  <= LINK_ADDR_ACK;
                isRead <= shiftReg[0];
                sdaLow <= 1'b1;
              end else begin
                state <= LINK_IDLE;
              end
            end
          end
          LINK_ADDR_ACK, LINK_HOST_ACK: begin
            if (state == LINK_HOST_ACK && hostNack) begin
              state  <= LINK_IDLE;
              sdaLow <= 1'b0;
            end else if (isRead) begin
              state   <= LINK_TX;
              txData  <= regBus.rdData;
              sdaLow  <= txPull(regBus.rdData, 4'h0);
              bitCnt  <= 4'h1;
              pointer <= nextPointer(pointer);
            end else begin
              state  <= LINK_RX;
              sdaLow <= 1'b0;
              bitCnt <= 4'h0;
            end
          end
          LINK_RX: begin
            if (isLastBit(bitCnt)) begin
              state  <= LINK_RX_ACK;
              sdaLow <= 1'b1;
              if (!gotPointer) begin
                pointer    <= shiftReg;
                gotPointer <= 1'b1;
              end else begin
                wrStrobe <= 1'b1;
                wrAddr   <= pointer;
                wrData   <= shiftReg;
                pointer  <= nextPointer(pointer);
              end
            end
          end
          LINK_RX_ACK: begin
            state  <= LINK_RX;
            sdaLow <= 1'b0;
            bitCnt <= 4'h0;
          end
          LINK_TX: begin
            if (isLastBit(bitCnt)) begin
              state  <= LINK_HOST_ACK;
              sdaLow <= 1'b0;
            end else begin
              sdaLow <= txPull(txData, bitCnt);
              bitCnt <= bitCnt + 4'h1;
            end
          end
          default: begin
          end
        endcase
      end
    end
  end
endmodule : threshold_deadtime_cfg_regs
`default_nettype wire

// ==== testbench/threshold_deadtime_cfg_regs_asserts.sv ====
`timescale 1ns/1ps
`default_nettype none
// ****
// Field checks
// ****
module threshold_deadtime_cfg_regs_asserts (
  input wire logic       clk_sys,
  input wire logic       resetn,
  input wire logic       sclIn,
  input wire logic [4:0] supplyDetectRiseCode,
  input wire logic [5:0] secondOvervoltageCode,
  input wire logic [1:0] syncPinRole,
  input wire logic       constDeadTimeEnable,
  input wire logic       deadTimeScalingEnable,
  input wire logic [1:0] minDeadTimeSelect,
  input wire logic [1:0] minOnOffTimeFactor
);
  logic [7:0] stage;
  assign stage = {syncPinRole, constDeadTimeEnable, deadTimeScalingEnable,
                  minDeadTimeSelect, minOnOffTimeFactor};
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  a_rise_reset: assert property ($rose(resetn) |-> supplyDetectRiseCode == 5'h03)
    else $error("rise code wrong after reset");
  a_ov_reset: assert property ($rose(resetn) |-> secondOvervoltageCode == 6'h3f)
    else $error("ov code wrong after reset");
  a_sync_reset: assert property ($rose(resetn) |-> syncPinRole == 2'h0 && !constDeadTimeEnable)
    else $error("sync or constant dead time wrong after reset");
  a_dead_reset: assert property ($rose(resetn) |-> deadTimeScalingEnable && minDeadTimeSelect == 2'h1)
    else $error("dead time fields wrong after reset");
  a_factor_reset: assert property ($rose(resetn) |-> minOnOffTimeFactor == 2'h1)
    else $error("on/off factor wrong after reset");
  a_rise_write_slot: assert property ($changed(supplyDetectRiseCode) |-> !sclIn && !$past(sclIn))
    else $error("rise code changed outside a write");
  a_ov_write_slot: assert property ($changed(secondOvervoltageCode) |-> !sclIn ##1 !sclIn)
    else $error("ov code changed outside a write");
  a_stage_hold_high: assert property (sclIn [*3] |-> $stable(stage))
    else $error("stage fields changed while clock high");
endmodule : threshold_deadtime_cfg_regs_asserts
bind threshold_deadtime_cfg_regs threshold_deadtime_cfg_regs_asserts chkInst (
  .clk_sys(clk_sys), .resetn(resetn), .sclIn(sclIn),
  .supplyDetectRiseCode(supplyDetectRiseCode), .secondOvervoltageCode(secondOvervoltageCode),
  .syncPinRole(syncPinRole), .constDeadTimeEnable(constDeadTimeEnable),
  .deadTimeScalingEnable(deadTimeScalingEnable), .minDeadTimeSelect(minDeadTimeSelect),
  .minOnOffTimeFactor(minOnOffTimeFactor));
`default_nettype wire

// ==== testbench/i2c_host_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// ****
// Host controller
// ****
module i2c_host_model (
  input  wire logic clk_sys,
  input  wire logic sdaLine,
  output var logic  scl,
  output var logic  sdaDrv
);
  initial begin
    scl = 1'b1;
    sdaDrv = 1'b1;
  end
  task automatic wt;
    repeat (4) @(posedge clk_sys);
    #1;
  endtask : wt
  task automatic start;
    sdaDrv = 1'b1;
    wt;
    scl = 1'b1;
    wt;
    sdaDrv = 1'b0;
    wt;
    scl = 1'b0;
    wt;
  endtask : start
  task automatic stop;
    sdaDrv = 1'b0;
    wt;
    scl = 1'b1;
    wt;
    sdaDrv = 1'b1;
    wt;
  endtask : stop
  // Eight data bits then the acknowledge bit, MSB first
  task automatic xfer(input logic [8:0] o, output logic [8:0] i);
    for (int k = 8; k >= 0; k--) begin
      sdaDrv = o[k];
      wt;
      scl = 1'b1;
      wt;
      i[k] = sdaLine;
      scl = 1'b0;
      wt;
    end
  endtask : xfer
endmodule : i2c_host_model
`default_nettype wire

// ==== testbench/tb_threshold_deadtime_cfg_regs.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb_threshold_deadtime_cfg_regs;
  import threshold_deadtime_pkg::*;
  localparam logic [6:0] DEV = 7'h50; // Arbitrary value
  logic       clkSys = 1'b0;
  logic       resetn = 1'b0;
  logic       scl, hostSda, sdaOut, sdaOe, constDt, scale;
  logic [4:0] rise;
  logic [5:0] ov;
  logic [1:0] sync, minDt, factor;
  wire logic  sdaLine = hostSda & ~sdaOe;
  int         nErrors = 0;
  int         samplesChecked = 0;
  always #10 clkSys = ~clkSys;
  i2c_host_model i2c_host_model_inst (.clk_sys(clkSys), .sdaLine(sdaLine), .scl(scl),
    .sdaDrv(hostSda));
  threshold_deadtime_cfg_regs #(.DEVICE_ADDRESS(DEV)) threshold_deadtime_cfg_regs_inst (
    .clk_sys(clkSys), .resetn(resetn), .sclIn(scl), .sdaIn(sdaLine), .sdaOut(sdaOut),
    .sdaOe(sdaOe), .supplyDetectRiseCode(rise), .secondOvervoltageCode(ov),
    .syncPinRole(sync), .constDeadTimeEnable(constDt), .deadTimeScalingEnable(scale),
    .minDeadTimeSelect(minDt), .minOnOffTimeFactor(factor));
  // ****
  // Helpers
  // ****
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samplesChecked++;
    if (got !== exp) begin
      nErrors++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic chkFields(input logic [7:0] r4, input logic [7:0] o5, input logic [7:0] s6);
    chk({3'h0, rise}, r4);
    chk({2'h0, ov}, o5);
    chk({sync, constDt, scale, minDt, factor}, s6);
  endtask : chkFields
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [8:0] r;
    i2c_host_model_inst.start;
    i2c_host_model_inst.xfer({DEV, 2'b01}, r);
    chk({7'h0, r[0]}, 8'h00);
    chk({7'h0, sdaOut}, 8'h00);
    i2c_host_model_inst.xfer({a, 1'b1}, r);
    i2c_host_model_inst.xfer({d, 1'b1}, r);
    chk({7'h0, r[0]}, 8'h00);
    i2c_host_model_inst.stop;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    logic [8:0] r;
    i2c_host_model_inst.start;
    i2c_host_model_inst.xfer({DEV, 2'b01}, r);
    i2c_host_model_inst.xfer({a, 1'b1}, r);
    i2c_host_model_inst.start;
    i2c_host_model_inst.xfer({DEV, 2'b11}, r);
    i2c_host_model_inst.xfer(9'h1ff, r);
    chk(r[8:1], exp);
    i2c_host_model_inst.stop;
  endtask : rd
  // ****
  // Scenarios
  // ****
  task automatic test_reset_values;
    chkFields(8'h03, 8'h3f, 8'h15);
    rd(SUPPLY_DETECT_RISE_LEVEL_OFS, 8'h03);
    rd(SECOND_OVERVOLTAGE_LEVEL_OFS, 8'h3f);
    rd(POWER_STAGE_TIMING_CONFIG_OFS, 8'h15);
    $display("test_reset_values done");
  endtask : test_reset_values
  task automatic test_unused_bits;
    wr(SUPPLY_DETECT_RISE_LEVEL_OFS, 8'hff);
    wr(SECOND_OVERVOLTAGE_LEVEL_OFS, 8'hd9);
    rd(SUPPLY_DETECT_RISE_LEVEL_OFS, 8'h1f);
    rd(SECOND_OVERVOLTAGE_LEVEL_OFS, 8'h19);
    chkFields(8'h1f, 8'h19, 8'h15);
    wr(SUPPLY_DETECT_RISE_LEVEL_OFS, 8'he0);
    wr(SECOND_OVERVOLTAGE_LEVEL_OFS, 8'h18);
    rd(SUPPLY_DETECT_RISE_LEVEL_OFS, 8'h00);
    chkFields(8'h00, 8'h18, 8'h15);
    $display("test_unused_bits done");
  endtask : test_unused_bits
  task automatic test_stage_codes;
    logic [1:0] c;
    logic [7:0] v;
    for (int k = 0; k < 4; k++) begin
      c = k[1:0];
      v = {c, c[0], ~c[0], c, ~c};
      wr(POWER_STAGE_TIMING_CONFIG_OFS, v);
      chkFields(8'h00, 8'h18, v);
      rd(POWER_STAGE_TIMING_CONFIG_OFS, v);
    end
    $display("test_stage_codes done");
  endtask : test_stage_codes
  task automatic test_burst;
    logic [8:0] r;
    i2c_host_model_inst.start;
    i2c_host_model_inst.xfer({DEV, 2'b01}, r);
    i2c_host_model_inst.xfer({SUPPLY_DETECT_RISE_LEVEL_OFS, 1'b1}, r);
    i2c_host_model_inst.xfer({8'h0a, 1'b1}, r);
    i2c_host_model_inst.xfer({8'h22, 1'b1}, r);
    i2c_host_model_inst.xfer({8'h2a, 1'b1}, r);
    chk({7'h0, r[0]}, 8'h00);
    i2c_host_model_inst.stop;
    chkFields(8'h0a, 8'h22, 8'h2a);
    i2c_host_model_inst.start;
    i2c_host_model_inst.xfer({DEV, 2'b01}, r);
    i2c_host_model_inst.xfer({SUPPLY_DETECT_RISE_LEVEL_OFS, 1'b1}, r);
    i2c_host_model_inst.start;
    i2c_host_model_inst.xfer({DEV, 2'b11}, r);
    i2c_host_model_inst.xfer(9'h1fe, r);
    chk(r[8:1], 8'h0a);
    i2c_host_model_inst.xfer(9'h1fe, r);
    chk(r[8:1], 8'h22);
    i2c_host_model_inst.xfer(9'h1ff, r);
    chk(r[8:1], 8'h2a);
    i2c_host_model_inst.stop;
    wr(8'hd7, 8'h5a);
    rd(8'hd7, 8'h00);
    chkFields(8'h0a, 8'h22, 8'h2a);
    $display("test_burst done");
  endtask : test_burst
  task automatic test_mid_reset;
    resetn = 1'b0;
    repeat (2) @(posedge clkSys);
    #1 resetn = 1'b1;
    repeat (2) @(posedge clkSys);
    #1;
    test_reset_values;
    $display("test_mid_reset done");
  endtask : test_mid_reset
  task automatic tally_and_finish;
    $display("checked %0d, errors %0d", samplesChecked, nErrors);
    if (nErrors == 0 && samplesChecked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : tally_and_finish
  initial begin
    repeat (6) @(posedge clkSys);
    #1 resetn = 1'b1;
    repeat (2) @(posedge clkSys);
    #1;
    test_reset_values;
    test_unused_bits;
    test_stage_codes;
    test_burst;
    test_mid_reset;
    tally_and_finish;
  end
  initial begin
    #1000000;
    nErrors++;
    tally_and_finish;
  end
endmodule : tb_threshold_deadtime_cfg_regs
`default_nettype wire
